//--- core/sbt_dev.sv
`timescale 1ns/10ps
// Summary of operation
// - eight byte registers, seven BCD coded plus the lock byte
// - single-byte and burst transfers supported
// - host opens each frame with command
// - host sends command before write data
// - command bit zero: 0 write, 1 read
// - command bits 3..1 select register
// - burst pattern on bits 7..1 selects burst
// - seconds bit 7 halts oscillator
// - lock set refuses writes except to the lock byte, keeps contents
// - lock in bit 7, others read zero
// - hours bit 7 picks 12/24 hour
// - hours bit 5 is PM or tens
// - calendar BCD ranges, unused bits zero
// - reset sets halt and lock
// - enable low aborts frame, floats data
// - sample on rise, drive after fall
// - LSB first, 16 or 72 clocks
// - write ignores extras, read repeats
module sbt_dev #(
  parameter int TICK_CYCLES = sbt_pkg::TICK_CYCLES
) (
  // system clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // link to host
  sbt_link_if.dev   lnk,
  // status
  output logic      halted,
  output logic      sec_tick
);

  typedef enum logic [1:0] {
    L_CMD = 2'b00,
    L_WR  = 2'b01,
    L_RD  = 2'b10,
    L_IGN = 2'b11
  } sbt_lst_t;

  // bcd increment of one byte
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  // last day of a bcd month, leap years every fourth year
  function automatic logic [7:0] month_end(input logic [7:0] mon,
                                           input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4
                    || yr[3:0] == 4'h8);
    case (mon)
      8'h02:   month_end = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
      default: month_end = 8'h31;
    endcase
  endfunction : month_end

  // ---------------- link domain, on the shift clock ----------------
  logic       lrst_n;
  sbt_lst_t   st_ff, nxt_st;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh;
  logic       burst_ff, nxt_burst;
  logic [2:0] addr_ff, nxt_addr;
  logic [5:0] rptr_ff, nxt_rptr;
  logic       wtgl_ff, nxt_wtgl;
  logic [2:0] wa_ff, nxt_wa;
  logic [7:0] wd_ff, nxt_wd;
  logic       drv_ff, nxt_drv;
  logic       out_ff, nxt_out;
  logic [7:0] snap_ff [sbt_pkg::NUM_REGS];

  // enable low clears the link frame registers at once, not the write request words
  assign lrst_n = nrst & lnk.en;

  // command decode and data shift, sampled on rising edge
  always_comb begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff + 3'h1;
    nxt_sh    = {lnk.io, sh_ff[7:1]};
    nxt_burst = burst_ff;
    nxt_addr  = addr_ff;
    nxt_rptr  = rptr_ff;
    nxt_wtgl  = wtgl_ff;
    nxt_wa    = wa_ff;
    nxt_wd    = wd_ff;
    case (st_ff)
      L_CMD: begin
        if (cnt_ff == 3'h7) begin
          if (nxt_sh[7:1] == sbt_pkg::BURST_PAT) begin
            nxt_burst = 1'b1;
            nxt_addr  = sbt_pkg::REG_SEC;
          end else begin
            nxt_burst = 1'b0;
            nxt_addr  = nxt_sh[sbt_pkg::CMD_SEL_LSB +: 3];
          end
          nxt_rptr = {nxt_addr, 3'h0};
          if (nxt_sh[7:1] != sbt_pkg::BURST_PAT
              && nxt_sh[7:4] != sbt_pkg::SINGLE_HI) begin
            nxt_st = L_IGN;
          end else if (nxt_sh[sbt_pkg::CMD_RD_BIT]) begin
            nxt_st = L_RD;
          end else begin
            nxt_st = L_WR;
          end
        end
      end
      L_WR: begin
        if (cnt_ff == 3'h7) begin
          // lock byte is not writable in burst
          if (!(burst_ff && addr_ff == sbt_pkg::REG_LOCK)) begin
            nxt_wa   = addr_ff;
            nxt_wd   = nxt_sh;
            nxt_wtgl = ~wtgl_ff;
          end
          if (burst_ff && addr_ff != sbt_pkg::REG_LOCK) begin
            nxt_addr = addr_ff + 3'h1;
          end else begin
            nxt_st = L_IGN;
          end
        end
      end
      L_RD: begin
        // single read wraps in its byte, burst over all eight
        if (burst_ff) begin
          nxt_rptr = rptr_ff + 6'h01;
        end else begin
          nxt_rptr = {rptr_ff[5:3], rptr_ff[2:0] + 3'h1};
        end
      end
      default: begin
        nxt_st = L_IGN;  // extra clocks change nothing
      end
    endcase
  end

  // link registers, rising edge
  always_ff @(posedge lnk.sclk or negedge lrst_n) begin
    if (!lrst_n) begin
      st_ff    <= L_CMD;
      cnt_ff   <= 3'h0;
      sh_ff    <= 8'h00;
      burst_ff <= 1'b0;
      addr_ff  <= 3'h0;
      rptr_ff  <= 6'h00;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      sh_ff    <= nxt_sh;
      burst_ff <= nxt_burst;
      addr_ff  <= nxt_addr;
      rptr_ff  <= nxt_rptr;
    end
  end

  // write request words survive the end of frame
  always_ff @(posedge lnk.sclk or negedge nrst) begin
    if (!nrst) begin
      wtgl_ff <= 1'b0;
      wa_ff   <= 3'h0;
      wd_ff   <= 8'h00;
    end else begin
      wtgl_ff <= nxt_wtgl;
      wa_ff   <= nxt_wa;
      wd_ff   <= nxt_wd;
    end
  end

  // read bit out after each falling edge
  always_comb begin
    nxt_drv = (st_ff == L_RD);
    nxt_out = snap_ff[rptr_ff[5:3]][rptr_ff[2:0]];
  end

  always_ff @(negedge lnk.sclk or negedge lrst_n) begin
    if (!lrst_n) begin
      drv_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      drv_ff <= nxt_drv;
      out_ff <= nxt_out;
    end
  end

  assign lnk.io_d      = out_ff;
  assign lnk.io_d_oe_n = ~(drv_ff & lnk.en);

  // ---------------- timekeeping domain, on clk ----------------
  logic        en_s1_ff, en_s2_ff;
  logic        wt_s1_ff, wt_s2_ff, wt_s3_ff;
  logic        wr_ev;
  logic [31:0] pre_ff, nxt_pre;
  logic        tick_ff, nxt_tick;
  logic [7:0]  bank_ff [sbt_pkg::NUM_REGS];
  logic [7:0]  nxt_bank [sbt_pkg::NUM_REGS];

  // enable level and write toggle cross by two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_s1_ff <= 1'b0;
      en_s2_ff <= 1'b0;
      wt_s1_ff <= 1'b0;
      wt_s2_ff <= 1'b0;
      wt_s3_ff <= 1'b0;
    end else begin
      en_s1_ff <= lnk.en;
      en_s2_ff <= en_s1_ff;
      wt_s1_ff <= wtgl_ff;
      wt_s2_ff <= wt_s1_ff;
      wt_s3_ff <= wt_s2_ff;
    end
  end

  assign wr_ev = wt_s2_ff ^ wt_s3_ff;

  // one-hertz prescaler, stopped by the halt flag
  always_comb begin
    nxt_pre  = pre_ff;
    nxt_tick = 1'b0;
    if (bank_ff[sbt_pkg::REG_SEC][sbt_pkg::HALT_BIT]) begin
      nxt_pre = 32'h0;
    end else if (pre_ff == 32'(TICK_CYCLES - 1)) begin
      nxt_pre  = 32'h0;
      nxt_tick = 1'b1;
    end else begin
      nxt_pre = pre_ff + 32'h1;
    end
  end

  // counting with carries, then a host write on top
  always_comb begin
    logic [7:0] s;
    logic [7:0] h;
    logic [7:0] hn;
    logic       c;
    s = 8'h00;
    h = 8'h00;
    hn = 8'h00;
    c = 1'b0;
    nxt_bank = bank_ff;
    if (tick_ff) begin
      s = {1'b0, bank_ff[sbt_pkg::REG_SEC][6:0]};
      c = (s == 8'h59);
      nxt_bank[sbt_pkg::REG_SEC] = c ? 8'h00 : bcd_inc(s);
      if (c) begin
        c = (bank_ff[sbt_pkg::REG_MIN] == 8'h59);
        nxt_bank[sbt_pkg::REG_MIN] =
          c ? 8'h00 : bcd_inc(bank_ff[sbt_pkg::REG_MIN]);
      end
      if (c) begin
        h = bank_ff[sbt_pkg::REG_HOUR];
        if (h[sbt_pkg::H12_BIT]) begin
          c = (h[4:0] == 5'h11) && h[sbt_pkg::PM_BIT];
          if (h[4:0] == 5'h11) begin
            nxt_bank[sbt_pkg::REG_HOUR] = {h[7:6], ~h[5], 5'h12};
          end else if (h[4:0] == 5'h12) begin
            nxt_bank[sbt_pkg::REG_HOUR] = {h[7:5], 5'h01};
          end else begin
            hn = bcd_inc({3'h0, h[4:0]});
            nxt_bank[sbt_pkg::REG_HOUR] = {h[7:5], hn[4:0]};
          end
        end else begin
          c = (h[5:0] == 6'h23);
          nxt_bank[sbt_pkg::REG_HOUR] = c ? 8'h00 : bcd_inc(h);
        end
      end
      if (c) begin
        nxt_bank[sbt_pkg::REG_DOW] = (bank_ff[sbt_pkg::REG_DOW] == 8'h07)
          ? 8'h01 : bcd_inc(bank_ff[sbt_pkg::REG_DOW]);
        c = (bank_ff[sbt_pkg::REG_DATE] == month_end(
               bank_ff[sbt_pkg::REG_MONTH], bank_ff[sbt_pkg::REG_YEAR]));
        nxt_bank[sbt_pkg::REG_DATE] =
          c ? 8'h01 : bcd_inc(bank_ff[sbt_pkg::REG_DATE]);
      end
      if (c) begin
        c = (bank_ff[sbt_pkg::REG_MONTH] == 8'h12);
        nxt_bank[sbt_pkg::REG_MONTH] =
          c ? 8'h01 : bcd_inc(bank_ff[sbt_pkg::REG_MONTH]);
      end
      if (c) begin
        nxt_bank[sbt_pkg::REG_YEAR] = (bank_ff[sbt_pkg::REG_YEAR] == 8'h99)
          ? 8'h00 : bcd_inc(bank_ff[sbt_pkg::REG_YEAR]);
      end
    end
    // lock byte writable even while locked, so it can be cleared
    if (wr_ev && (wa_ff == sbt_pkg::REG_LOCK
        || !bank_ff[sbt_pkg::REG_LOCK][sbt_pkg::LOCK_BIT])) begin
      nxt_bank[wa_ff] = wd_ff & sbt_pkg::WR_MASK[wa_ff];
    end
  end

  // bank and prescaler registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_ff  <= 32'h0;
      tick_ff <= 1'b0;
      bank_ff <= sbt_pkg::RST_VAL;
    end else begin
      pre_ff  <= nxt_pre;
      tick_ff <= nxt_tick;
      bank_ff <= nxt_bank;
    end
  end

  // snapshot follows the bank between frames, frozen during one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      snap_ff <= sbt_pkg::RST_VAL;
    end else if (!en_s2_ff) begin
      snap_ff <= bank_ff;
    end
  end

  assign halted   = bank_ff[sbt_pkg::REG_SEC][sbt_pkg::HALT_BIT];
  assign sec_tick = tick_ff;

endmodule : sbt_dev

//--- core/sbt_pkg.sv
package sbt_pkg;
  // register indices in the bank
  localparam logic [2:0] REG_SEC   = 3'h0;
  localparam logic [2:0] REG_MIN   = 3'h1;
  localparam logic [2:0] REG_HOUR  = 3'h2;
  localparam logic [2:0] REG_DATE  = 3'h3;
  localparam logic [2:0] REG_MONTH = 3'h4;
  localparam logic [2:0] REG_DOW   = 3'h5;
  localparam logic [2:0] REG_YEAR  = 3'h6;
  localparam logic [2:0] REG_LOCK  = 3'h7;
  localparam int         NUM_REGS  = 8;

  // field positions
  localparam int HALT_BIT = 7;  // oscillator_halt_flag in seconds
  localparam int LOCK_BIT = 7;  // write lock flag
  localparam int H12_BIT  = 7;  // 12-hour format select
  localparam int PM_BIT   = 5;  // afternoon_flag in 12-hour format

  // writable bits of each register; the others read as zero
  localparam logic [7:0] WR_MASK [NUM_REGS] = '{
    8'hFF, 8'h7F, 8'hBF, 8'h3F, 8'h1F, 8'h07, 8'hFF, 8'h80};

  // reset values: clock halted, bank locked
  localparam logic [7:0] RST_VAL [NUM_REGS] = '{
    8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h80};

  // command byte decode
  localparam int         CMD_RD_BIT   = 0;
  localparam int         CMD_SEL_LSB  = 1;
  localparam logic [6:0] BURST_PAT    = 7'h5F;  // c7..c1 = 1011111
  localparam logic [3:0] SINGLE_HI    = 4'h8;   // c7..c4 = 1000
  localparam logic [3:0] TEST_HI      = 4'h9;   // c7..c4 = 1001

  // frame lengths in shift clocks
  localparam int CMD_BITS    = 8;
  localparam int SINGLE_CLKS = 16;
  localparam int BURST_CLKS  = 72;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES   =
    TICK_PERIOD_S * (1000000000 / CLK_PERIOD_NS);
  localparam int HOST_HALF_CYC = 4;  // half shift-clock period in clk
endpackage : sbt_pkg

//--- core/sbt_link_if.sv
`timescale 1ns/10ps
interface sbt_link_if;
  logic sclk;       // shift clock, made by host
  logic en;         // transfer_enable_pin, high during a frame
  logic io_h;       // host data out
  logic io_h_oe_n;  // host drives data pin when low
  logic io_d;       // device data out
  logic io_d_oe_n;  // device drives data pin when low
  logic io;         // resolved data pin level

  // resolved level; an undriven pin is pulled high
  assign io = !io_h_oe_n ? io_h : (!io_d_oe_n ? io_d : 1'b1);

  modport dev (input sclk, input en, input io,
               output io_d, output io_d_oe_n);
  modport host (output sclk, output en, output io_h, output io_h_oe_n,
                input io);
endinterface : sbt_link_if

//--- core/sbt_host.sv
`timescale 1ns/10ps
module sbt_host #(
  parameter int HALF = sbt_pkg::HOST_HALF_CYC
) (
  // system clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // user request
  input  wire logic        start,
  input  wire logic [7:0]  cmd,
  input  wire logic [63:0] wdata,
  // user answer
  output logic             busy,
  output logic             done,
  output logic [63:0]      rdata,
  // link to device
  sbt_link_if.host         lnk
);

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SETUP = 3'b001,
    H_LOW   = 3'b010,
    H_HIGH  = 3'b011,
    H_END   = 3'b100
  } sbt_hst_t;

  sbt_hst_t    st_ff, nxt_st;
  logic [15:0] div_ff, nxt_div;
  logic [6:0]  bit_ff, nxt_bit;
  logic [6:0]  last_ff, nxt_last;
  logic [7:0]  cmd_ff, nxt_cmd;
  logic [63:0] wd_ff, nxt_wd;
  logic [63:0] rd_ff, nxt_rd;
  logic        sclk_ff, nxt_sclk;
  logic        en_ff, nxt_en;
  logic        io_ff, nxt_io;
  logic        oen_ff, nxt_oen;
  logic        done_ff, nxt_done;
  logic        io_s1_ff, io_s2_ff;
  logic        rd_mode;
  logic        half_up;

  assign rd_mode = cmd_ff[sbt_pkg::CMD_RD_BIT];
  assign half_up = (div_ff == 16'(HALF - 1));

  // data pin crosses into clk by two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      io_s1_ff <= 1'b1;
      io_s2_ff <= 1'b1;
    end else begin
      io_s1_ff <= lnk.io;
      io_s2_ff <= io_s1_ff;
    end
  end

  // frame sequencer, shift clock divided from clk
  always_comb begin
    nxt_st   = st_ff;
    nxt_div  = half_up ? 16'h0 : div_ff + 16'h1;
    nxt_bit  = bit_ff;
    nxt_last = last_ff;
    nxt_cmd  = cmd_ff;
    nxt_wd   = wd_ff;
    nxt_rd   = rd_ff;
    nxt_sclk = sclk_ff;
    nxt_en   = en_ff;
    nxt_io   = io_ff;
    nxt_oen  = oen_ff;
    nxt_done = 1'b0;
    case (st_ff)
      H_IDLE: begin
        nxt_div = 16'h0;
        if (start) begin
          nxt_cmd  = cmd;
          nxt_wd   = wdata;
          nxt_en   = 1'b1;
          nxt_sclk = 1'b0;
          nxt_bit  = 7'h0;
          nxt_last = (cmd[7:1] == sbt_pkg::BURST_PAT)
                     ? 7'(sbt_pkg::BURST_CLKS - 1)
                     : 7'(sbt_pkg::SINGLE_CLKS - 1);
          nxt_st   = H_SETUP;
        end
      end
      H_SETUP, H_HIGH: begin
        if (half_up) begin
          if (st_ff == H_HIGH && bit_ff == last_ff) begin
            nxt_sclk = 1'b0;
            nxt_oen  = 1'b1;
            nxt_st   = H_END;
          end else begin
            if (st_ff == H_HIGH) begin
              nxt_bit = bit_ff + 7'h1;
            end
            nxt_sclk = 1'b0;
            nxt_st   = H_LOW;
            // command first, then write data, lsb first
            if (nxt_bit < 7'(sbt_pkg::CMD_BITS)) begin
              nxt_io  = cmd_ff[nxt_bit[2:0]];
              nxt_oen = 1'b0;
            end else if (!rd_mode) begin
              nxt_io  = wd_ff[6'(nxt_bit - 7'(sbt_pkg::CMD_BITS))];
              nxt_oen = 1'b0;
            end else begin
              nxt_oen = 1'b1;
            end
          end
        end
      end
      H_LOW: begin
        if (half_up) begin
          nxt_sclk = 1'b1;
          nxt_st   = H_HIGH;
          if (rd_mode && bit_ff >= 7'(sbt_pkg::CMD_BITS)) begin
            nxt_rd[6'(bit_ff - 7'(sbt_pkg::CMD_BITS))] = io_s2_ff;
          end
        end
      end
      H_END: begin
        if (half_up) begin
          nxt_en   = 1'b0;
          nxt_done = 1'b1;
          nxt_st   = H_IDLE;
        end
      end
      default: begin
        nxt_st = H_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff   <= H_IDLE;
      div_ff  <= 16'h0;
      bit_ff  <= 7'h0;
      last_ff <= 7'h0;
      cmd_ff  <= 8'h00;
      wd_ff   <= 64'h0;
      rd_ff   <= 64'h0;
      sclk_ff <= 1'b0;
      en_ff   <= 1'b0;
      io_ff   <= 1'b0;
      oen_ff  <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      div_ff  <= nxt_div;
      bit_ff  <= nxt_bit;
      last_ff <= nxt_last;
      cmd_ff  <= nxt_cmd;
      wd_ff   <= nxt_wd;
      rd_ff   <= nxt_rd;
      sclk_ff <= nxt_sclk;
      en_ff   <= nxt_en;
      io_ff   <= nxt_io;
      oen_ff  <= nxt_oen;
      done_ff <= nxt_done;
    end
  end

  assign lnk.sclk      = sclk_ff;
  assign lnk.en        = en_ff;
  assign lnk.io_h      = io_ff;
  assign lnk.io_h_oe_n = oen_ff;
  assign busy          = (st_ff != H_IDLE);
  assign done          = done_ff;
  assign rdata         = rd_ff;

endmodule : sbt_host

//--- sim/sbt_link_assertions.sv
`timescale 1ns/10ps
// watches the three-wire link between host end and timekeeper end
module sbt_link_assertions (
  // system clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link signals
  input wire logic sclk,
  input wire logic en,
  input wire logic io_h,
  input wire logic io_h_oe_n,
  input wire logic io_d,
  input wire logic io_d_oe_n,
  input wire logic io
);
  logic [6:0] rise_ff;
  logic [6:0] nxt_rise;
  logic       sclk_ff;
  logic       nxt_sclk;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // counts shift-clock rises within the current frame
  always_comb begin
    nxt_sclk = sclk;
    nxt_rise = !en ? 7'h00 : rise_ff + {6'h00, sclk & ~sclk_ff};
  end

  // registers the rise counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rise_ff <= 7'h00;
      sclk_ff <= 1'b0;
    end else begin
      rise_ff <= nxt_rise;
      sclk_ff <= nxt_sclk;
    end
  end

  property p_float;      !en |-> io_d_oe_n; endproperty
  property p_one_drv;    io_h_oe_n || io_d_oe_n; endproperty
  property p_pull;       io_h_oe_n && io_d_oe_n |-> io; endproperty
  property p_idle_clk;   !en |-> !sclk; endproperty
  property p_drive_low;  $fell(io_d_oe_n) |-> !sclk; endproperty
  property p_dev_hold;
    sclk && $past(sclk) && !io_d_oe_n |-> $stable(io_d);
  endproperty
  property p_host_hold;
    sclk && $past(sclk) && !io_h_oe_n |-> $stable(io_h);
  endproperty
  property p_high_len;   $rose(sclk) |-> sclk [*4]; endproperty
  property p_frame_len;
    $fell(en) |-> (rise_ff == 7'h10 || rise_ff == 7'h48);
  endproperty
  property p_no_early;   !io_d_oe_n |-> rise_ff >= 7'h08; endproperty

  a_float:     assert property (p_float)
    else $error("device drives data pin outside a frame");
  a_one_drv:   assert property (p_one_drv)
    else $error("both ends drive the data pin");
  a_pull:      assert property (p_pull)
    else $error("released data pin not at idle level");
  a_idle_clk:  assert property (p_idle_clk)
    else $error("shift clock high outside a frame");
  a_drive_low: assert property (p_drive_low)
    else $error("device starts driving while shift clock high");
  a_dev_hold:  assert property (p_dev_hold)
    else $error("device data changes while shift clock high");
  a_host_hold: assert property (p_host_hold)
    else $error("host data changes while shift clock high");
  a_high_len:  assert property (p_high_len)
    else $error("shift clock high phase too short");
  a_frame_len: assert property (p_frame_len)
    else $error("frame not 16 or 72 shift clocks");
  a_no_early:  assert property (p_no_early)
    else $error("device drives before command complete");

  c_burst:  cover property ($fell(en) && rise_ff == 7'h48);
  c_single: cover property ($fell(en) && rise_ff == 7'h10);
  c_read:   cover property ($fell(io_d_oe_n));
endmodule : sbt_link_assertions

//--- sim/serial_bcd_timekeeper_regs_tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
  n_fail++; \
  $display("unexpected at %0t: got %h exp %h", $time, got, exp); end end
module serial_bcd_timekeeper_regs_tb;
  logic        clk    = 1'b0;
  logic        nrst   = 1'b0;
  logic        start  = 1'b0;
  logic [7:0]  cmd    = 8'h00;
  logic [63:0] wdata  = 64'h0;
  logic        busy;
  logic        done;
  logic [63:0] rdata;
  logic        halted;
  logic        sec_tick;
  int          n_fail   = 0;
  int          compares = 0;

  sbt_link_if lnk_if ();
  sbt_dev #(.TICK_CYCLES(2000)) sbt_dev_inst (.clk(clk), .nrst(nrst),
    .lnk(lnk_if), .halted(halted), .sec_tick(sec_tick));
  sbt_host sbt_host_inst (.clk(clk), .nrst(nrst), .start(start),
    .cmd(cmd), .wdata(wdata), .busy(busy), .done(done), .rdata(rdata),
    .lnk(lnk_if));
  sbt_link_assertions sbt_link_assertions_inst (.clk(clk), .nrst(nrst),
    .sclk(lnk_if.sclk), .en(lnk_if.en), .io_h(lnk_if.io_h),
    .io_h_oe_n(lnk_if.io_h_oe_n), .io_d(lnk_if.io_d),
    .io_d_oe_n(lnk_if.io_d_oe_n), .io(lnk_if.io));

  // system clock
  always #5 clk = ~clk;

  // prints counts and verdict, ends the run
  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // one frame through the host, then idle gap between frames
  task automatic xfer(input logic [7:0] c, input logic [63:0] w);
    int k;
    @(posedge clk);
    start <= 1'b1;
    cmd   <= c;
    wdata <= w;
    @(posedge clk);
    start <= 1'b0;
    #1;
    `CHK(busy, 1'b1)
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 2000);
    `CHK(done, 1'b1)
    `CHK(busy, 1'b0)
    repeat (4) @(posedge clk);
  endtask : xfer

  task automatic wr1(input logic [2:0] r, input logic [7:0] d);
    xfer({4'h8, r, 1'b0}, {56'h0, d});
  endtask : wr1

  task automatic rd1(input logic [2:0] r, input logic [7:0] e);
    xfer({4'h8, r, 1'b1}, 64'h0);
    `CHK(rdata[7:0], e)
  endtask : rd1

  // waits for n sec_tick pulses, 2000 clk cycles apart here
  task automatic wait_ticks(input int n);
    int got;
    int k;
    got = 0;
    for (k = 0; k < 10000 && got < n; k++) begin
      @(posedge clk);
      #1;
      if (sec_tick === 1'b1) got++;
    end
    `CHK(got, n)
  endtask : wait_ticks

  // reset values of every register by single reads
  task automatic t_reset();
    `CHK(halted, 1'b1)
    for (int r = 0; r < 8; r++) begin
      rd1(3'(r), sbt_pkg::RST_VAL[r]);
    end
  endtask : t_reset

  // lock refuses writes, lock register layout, unused bits
  task automatic t_lock();
    wr1(3'h1, 8'h42);
    rd1(3'h1, 8'h00);
    wr1(3'h7, 8'hFF);
    rd1(3'h7, 8'h80);
    wr1(3'h7, 8'h00);
    wr1(3'h1, 8'h42);
    rd1(3'h1, 8'h42);
    wr1(3'h4, 8'hF2);
    rd1(3'h4, 8'h12);
  endtask : t_lock

  // test-mode and unknown commands have no effect
  task automatic t_refuse();
    xfer(8'h93, 64'h0);
    `CHK(rdata[7:0], 8'hFF)
    xfer(8'h02, 64'h11);
    rd1(3'h1, 8'h42);
  endtask : t_refuse

  // burst write and read; lock byte not written in burst
  task automatic t_burst();
    xfer(8'hBE, 64'h80_24_03_12_31_23_59_D9);
    xfer(8'hBF, 64'h0);
    `CHK(rdata, 64'h00_24_03_12_31_23_59_D9)
    `CHK(halted, 1'b1)
  endtask : t_burst

  // full carry from seconds to year in 24-hour mode
  task automatic t_tick();
    xfer(8'hBE, 64'h00_99_07_12_31_23_59_58);
    wait_ticks(2);
    xfer(8'hBF, 64'h0);
    `CHK(rdata, 64'h00_00_01_01_01_00_00_00)
    `CHK(halted, 1'b0)
  endtask : t_tick

  // 11 AM rolls to 12 PM in 12-hour mode
  task automatic t_12h();
    xfer(8'hBE, 64'h00_24_03_12_15_91_59_58);
    wait_ticks(2);
    xfer(8'hBF, 64'h0);
    `CHK(rdata, 64'h00_24_03_12_15_B2_00_00)
  endtask : t_12h

  // leap day and 11 PM carry into the next day in 12-hour mode
  task automatic t_leap();
    xfer(8'hBE, 64'h00_24_03_02_28_B1_59_58);
    wait_ticks(2);
    xfer(8'hBF, 64'h0);
    `CHK(rdata, 64'h00_24_04_02_29_92_00_00)
  endtask : t_leap

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_lock();
    t_refuse();
    t_burst();
    t_tick();
    t_12h();
    t_leap();
    report_and_stop();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    $display("unexpected at %0t: got %h exp %h", $time, 1'b0, 1'b1);
    report_and_stop();
  end
endmodule : serial_bcd_timekeeper_regs_tb
